// ### bench/cic_rate_change_filter_monitor.sv
`timescale 1ns/100ps
module cic_rate_change_filter_monitor
    import cic_pkg::*;
(
    // Watched ports
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic new_sample_valid_i,
    input wire logic accept_ready_o,
    input wire logic [cic_pkg::CIC_W-1:0] sample_out_o,
    input wire logic out_valid_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Cycles since the last offered sample, saturating
    logic [3:0] idle_reg;
    always_ff @(posedge sys_clk_i) begin
        idle_reg <= (new_sample_valid_i || !rst_n_i) ? 4'h0 : idle_reg + {3'h0, idle_reg != 4'hF};
    end
    AST_READY: assert property (CIC_DECIMATOR |-> accept_ready_o)
        else $error("ready low");
    AST_HOLD: assert property ($changed(sample_out_o) |-> out_valid_o)
        else $error("output moved");
    AST_LAT: assert property (out_valid_o |-> $past(new_sample_valid_i, 11))
        else $error("output latency");
    AST_SPACE: assert property (out_valid_o |=> !out_valid_o [*3])
        else $error("outputs too close");
    AST_IDLE: assert property (idle_reg >= 4'hC |-> !out_valid_o)
        else $error("output without input");
    AST_QUIET: assert property ($rose(rst_n_i) |-> !out_valid_o [*8])
        else $error("early output");
    AST_ZERO: assert property ($rose(rst_n_i) |-> sample_out_o == '0)
        else $error("output not cleared");
    AST_RDY_RST: assert property ($rose(rst_n_i) |-> accept_ready_o)
        else $error("ready low at start");
endmodule
bind cic_rate_change_filter cic_rate_change_filter_monitor i_monitor (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .new_sample_valid_i(new_sample_valid_i),
    .accept_ready_o(accept_ready_o), .sample_out_o(sample_out_o), .out_valid_o(out_valid_o));

// ### bench/cic_rate_change_filter_test.sv
`timescale 1ns/100ps
module cic_rate_change_filter_test;
    import cic_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] period = 4'h0;
    logic [CIC_IN_W-1:0] value = '0;
    logic [CIC_RATE_W-1:0] rate_val = '0;
    logic rate_stb = 1'b0;
    logic [CIC_IN_W-1:0] din;
    logic nd, rdy, ov;
    logic [CIC_W-1:0] dout, last;
    int gap, cnt;
    int mismatches = 0;
    int compares = 0;
    always #50 sys_clk_i = ~sys_clk_i;
    cic_rate_change_filter i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sample_in_i(din),
        .new_sample_valid_i(nd), .accept_ready_o(rdy), .sample_out_o(dout), .out_valid_o(ov),
        .rate_load_value_i(rate_val), .rate_load_strobe_i(rate_stb));
    cic_stream_model i_model (.sys_clk_i(sys_clk_i), .period_i(period), .value_i(value), .ready_i(rdy),
        .sample_o(din), .valid_o(nd), .out_valid_i(ov), .out_i(dout), .last_o(last), .gap_o(gap), .cnt_o(cnt));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [CIC_W-1:0] exp, input logic [CIC_W-1:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Ten more outputs let the pipeline settle to the DC level x * r^N
    task automatic dc_check(input logic signed [CIC_IN_W-1:0] x, input int r, input int sp);
        logic signed [CIC_W-1:0] e;
        int t;
        e = x;
        t = cnt + 10;
        for (int i = 0; i < 900 && cnt < t; i++) @(negedge sys_clk_i);
        check("outputs", t, cnt);
        check("gap", sp, gap);
        check("dc_level", e * r * r * r * r, last);
    endtask
    task automatic t_reset;
        repeat (14) @(negedge sys_clk_i);
        check("out_valid", '0, ov);
        check("sample_out", '0, dout);
        check("accept_ready", 1, rdy);
        check("out_width", 65, $bits(dout));
    endtask
    task automatic t_full;
        int k;
        k = 0;
        period <= 4'h1;
        value <= 10'h001;
        while (ov !== 1'b1 && k < 99) begin
            @(negedge sys_clk_i);
            k++;
        end
        check("first_latency", 2 * CIC_STAGES + 3 + int'(CIC_RATE_INIT), k);
        dc_check(10'h001, 4, 4);
        value <= 10'h3FF;
        dc_check(10'h3FF, 4, 4);
    endtask
    task automatic t_sparse;
        period <= 4'h2;
        value <= 10'h003;
        dc_check(10'h003, 4, 8);
    endtask
    task automatic t_rate;
        logic [CIC_RATE_W-1:0] v [2] = '{14'h0005, 14'h0002};
        int r [2] = '{5, 4};
        period <= 4'h1;
        value <= 10'h002;
        foreach (v[i]) begin
            rate_val <= v[i];
            rate_stb <= 1'b1;
            @(negedge sys_clk_i);
            rate_stb <= 1'b0;
            dc_check(10'h002, r[i], r[i]);
        end
    endtask
    task automatic results;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge sys_clk_i);
        rst_n_i <= 1'b1;
        t_reset;
        t_full;
        t_sparse;
        t_rate;
        results;
    end
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        mismatches++;
        results;
    end
endmodule

// ### bench/cic_stream_model.sv
`timescale 1ns/100ps
module cic_stream_model
    import cic_pkg::*;
(
    // Source side
    input wire logic sys_clk_i,
    input wire logic [3:0] period_i,
    input wire logic [cic_pkg::CIC_IN_W-1:0] value_i,
    input wire logic ready_i,
    output logic [cic_pkg::CIC_IN_W-1:0] sample_o = '0,
    output logic valid_o = 1'b0,
    // Consumer side
    input wire logic out_valid_i,
    input wire logic [cic_pkg::CIC_W-1:0] out_i,
    output logic [cic_pkg::CIC_W-1:0] last_o,
    output int gap_o = 0,
    output int cnt_o = 0
);
    int wait_c = 0;
    int since = 0;
    // Period zero stops the source; the bus toggles while no sample is offered
    wire go = period_i != 4'h0 && ready_i && wait_c == 0;
    always @(negedge sys_clk_i) begin
        valid_o <= go;
        sample_o <= go ? value_i : ~sample_o;
        wait_c <= go ? int'(period_i) - 1 : (wait_c > 0 ? wait_c - 1 : 0);
    end
    always @(posedge sys_clk_i) begin
        since <= since + 1;
        if (out_valid_i === 1'b1) begin
            last_o <= out_i;
            gap_o <= since + 1;
            cnt_o <= cnt_o + 1;
            since <= 0;
        end
    end
endmodule

// ### logic/cic_integ_chain.sv
`timescale 1ns/100ps
module cic_integ_chain
    import cic_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Sample in
    input wire logic sample_valid_i,
    input wire logic [cic_pkg::CIC_W-1:0] sample_i,
    // Sample out
    output logic result_valid_o,
    output logic [cic_pkg::CIC_W-1:0] result_o
);
    import cic_pkg::*;

    typedef struct packed {
        logic [CIC_STAGES-1:0] vld;
        logic [CIC_STAGES-1:0][CIC_W-1:0] acc;
    } cic_integ_state_t;

    cic_integ_state_t st_reg;
    cic_integ_state_t st_next;

    ////////////////////////////////////////////////////////////////////////////
    // One adder per stage; each stage accumulates only on a qualified sample
    always_comb begin
        st_next = st_reg;
        for (int i = 0; i < CIC_STAGES; i++) begin
            if (i == 0) begin
                st_next.vld[i] = sample_valid_i;
                if (sample_valid_i) begin
                    st_next.acc[i] = st_reg.acc[i] + sample_i;
                end
            end else begin
                st_next.vld[i] = st_reg.vld[i-1];
                if (st_reg.vld[i-1]) begin
                    st_next.acc[i] = st_reg.acc[i] + st_reg.acc[i-1];
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign result_valid_o = st_reg.vld[CIC_STAGES-1];
    assign result_o = st_reg.acc[CIC_STAGES-1];

endmodule

// ### logic/cic_pkg.sv
package cic_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Build configuration
    localparam int CIC_IN_W = 10;
    localparam int CIC_STAGES = 4;
    // Differential delay, 1 or 2 only
    localparam int CIC_DIFF_DELAY = 1;
    localparam bit CIC_DECIMATOR = 1'b1;
    localparam bit CIC_PROG_RATE = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Rate-change factor
    localparam int CIC_RATE_W = 14;
    localparam logic [CIC_RATE_W-1:0] CIC_RATE_MIN = 14'h0004;
    localparam logic [CIC_RATE_W-1:0] CIC_RATE_MAX = 14'h3FFF;
    localparam logic [CIC_RATE_W-1:0] CIC_RATE_INIT = 14'h0004;
    localparam logic [CIC_RATE_W-1:0] CIC_RATE_ONE = 14'h0001;
    localparam logic [CIC_RATE_W-1:0] CIC_CNT_ZERO = 14'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Register growth: smallest k with 2^k >= (rate*m)^n
    function automatic int cic_growth(input int rate, input int m, input int n);
        longint unsigned p;
        int k;
        p = 64'h1;
        k = 0;
        for (int i = 0; i < n; i++) begin
            p = p * longint'(rate * m);
        end
        for (int j = 0; j < 63; j++) begin
            if ((64'h1 << j) < p) begin
                k = j + 1;
            end
        end
        return k;
    endfunction

    localparam int CIC_GROWTH_RATE = (CIC_DECIMATOR && CIC_PROG_RATE) ? int'(CIC_RATE_MAX) : int'(CIC_RATE_INIT);
    localparam int CIC_W = cic_growth(CIC_GROWTH_RATE, CIC_DIFF_DELAY, CIC_STAGES) + CIC_IN_W - 1;

    ////////////////////////////////////////////////////////////////////////////
    // Sign extension of an input sample to the internal width
    function automatic logic [CIC_W-1:0] cic_sext(input logic [CIC_IN_W-1:0] x);
        return {{(CIC_W-CIC_IN_W){x[CIC_IN_W-1]}}, x};
    endfunction

endpackage

// ### logic/cic_rate_change_filter.sv
`timescale 1ns/100ps
// Overview of operation
// - All stages carry full growth width internally
// - Input word captured on edge with qualifier
// - Qualifier low means no sample enters
// - Input B bits, output W bits wide
// - Output valid marks each new output cycle
// - Ready high whenever input can be accepted
// - Rate latched from load bus on strobe
// - Rate load only in programmable decimator
// - Same ports in both filter modes
// - Decimator outputs every R accepted samples
// - Sparse input stretches output spacing accordingly
// - Interpolator gives R outputs per input
// - Valid drops where no interpolant exists
// - Output bus holds last sample between outputs
// - Differential delay restricted to one or two
// - Expander inserts zeros between comb outputs
// - Rate factor supported from 4 to 16383
module cic_rate_change_filter
    import cic_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Sample input
    input wire logic [cic_pkg::CIC_IN_W-1:0] sample_in_i,
    input wire logic new_sample_valid_i,
    output logic accept_ready_o,
    // Sample output
    output logic [cic_pkg::CIC_W-1:0] sample_out_o,
    output logic out_valid_o,
    // Rate load
    input wire logic [cic_pkg::CIC_RATE_W-1:0] rate_load_value_i,
    input wire logic rate_load_strobe_i
);
    import cic_pkg::*;

    typedef struct packed {
        logic [CIC_RATE_W-1:0] rate;
        logic [CIC_RATE_W-1:0] dec_cnt;
        logic [CIC_RATE_W-1:0] gap_cnt;
        logic [CIC_RATE_W-1:0] exp_cnt;
        logic in_vld;
        logic [CIC_W-1:0] in_smp;
        logic dec_vld;
        logic [CIC_W-1:0] dec_smp;
        logic [CIC_STAGES-1:0] cv;
        logic [CIC_STAGES-1:0][CIC_W-1:0] cy;
        logic [CIC_STAGES-1:0][CIC_W-1:0] d0;
        logic [CIC_STAGES-1:0][CIC_W-1:0] d1;
        logic exp_vld;
        logic [CIC_W-1:0] exp_smp;
        logic out_vld;
        logic [CIC_W-1:0] out_smp;
    } cic_state_t;

    cic_state_t st_reg;
    cic_state_t st_next;

    logic accept;
    logic integ_in_vld;
    logic [CIC_W-1:0] integ_in;
    logic integ_vld;
    logic [CIC_W-1:0] integ_out;

    ////////////////////////////////////////////////////////////////////////////
    // Input handshake
    always_comb begin
        if (CIC_DECIMATOR) begin
            accept_ready_o = 1'b1;
        end else begin
            // One input per R clocks keeps expander bursts from overlapping
            accept_ready_o = (st_reg.gap_cnt == CIC_CNT_ZERO);
        end
    end

    assign accept = new_sample_valid_i & accept_ready_o;

    ////////////////////////////////////////////////////////////////////////////
    // Integrator section feed selects by mode
    always_comb begin
        if (CIC_DECIMATOR) begin
            integ_in_vld = st_reg.in_vld;
            integ_in = st_reg.in_smp;
        end else begin
            integ_in_vld = st_reg.exp_vld;
            integ_in = st_reg.exp_smp;
        end
    end

    cic_integ_chain u_integ (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .sample_valid_i(integ_in_vld),
        .sample_i(integ_in),
        .result_valid_o(integ_vld),
        .result_o(integ_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic src_vld;
        logic [CIC_W-1:0] src;
        logic x_vld;
        logic [CIC_W-1:0] x;
        logic [CIC_W-1:0] dly;
        src_vld = 1'b0;
        src = '0;
        x_vld = 1'b0;
        x = '0;
        dly = '0;
        st_next = st_reg;

        // Rate load
        if (CIC_DECIMATOR && CIC_PROG_RATE && rate_load_strobe_i) begin
            if (rate_load_value_i < CIC_RATE_MIN) begin
                st_next.rate = CIC_RATE_MIN;
            end else begin
                st_next.rate = rate_load_value_i;
            end
            st_next.dec_cnt = CIC_CNT_ZERO;
        end

        // Input capture
        st_next.in_vld = accept;
        if (accept) begin
            st_next.in_smp = cic_sext(sample_in_i);
        end

        // Input pacing for the interpolator
        if (accept) begin
            st_next.gap_cnt = st_reg.rate - CIC_RATE_ONE;
        end else if (st_reg.gap_cnt != CIC_CNT_ZERO) begin
            st_next.gap_cnt = st_reg.gap_cnt - CIC_RATE_ONE;
        end

        // Decimation switch
        st_next.dec_vld = 1'b0;
        if (CIC_DECIMATOR && integ_vld) begin
            if (st_reg.dec_cnt >= st_reg.rate - CIC_RATE_ONE) begin
                st_next.dec_vld = 1'b1;
                st_next.dec_smp = integ_out;
                st_next.dec_cnt = CIC_CNT_ZERO;
            end else begin
                st_next.dec_cnt = st_reg.dec_cnt + CIC_RATE_ONE;
            end
        end

        // Comb section source
        if (CIC_DECIMATOR) begin
            src_vld = st_reg.dec_vld;
            src = st_reg.dec_smp;
        end else begin
            src_vld = st_reg.in_vld;
            src = st_reg.in_smp;
        end

        // Comb stages, one subtractor between registers
        for (int i = 0; i < CIC_STAGES; i++) begin
            if (i == 0) begin
                x_vld = src_vld;
                x = src;
            end else begin
                x_vld = st_reg.cv[i-1];
                x = st_reg.cy[i-1];
            end
            if (CIC_DIFF_DELAY == 2) begin
                dly = st_reg.d1[i];
            end else begin
                dly = st_reg.d0[i];
            end
            st_next.cv[i] = x_vld;
            if (x_vld) begin
                st_next.cy[i] = x - dly;
                st_next.d0[i] = x;
                st_next.d1[i] = st_reg.d0[i];
            end
        end

        // Rate expander
        if (!CIC_DECIMATOR && st_reg.cv[CIC_STAGES-1]) begin
            st_next.exp_vld = 1'b1;
            st_next.exp_smp = st_reg.cy[CIC_STAGES-1];
            st_next.exp_cnt = st_reg.rate - CIC_RATE_ONE;
        end else if (st_reg.exp_cnt != CIC_CNT_ZERO) begin
            st_next.exp_vld = 1'b1;
            st_next.exp_smp = '0;
            st_next.exp_cnt = st_reg.exp_cnt - CIC_RATE_ONE;
        end else begin
            st_next.exp_vld = 1'b0;
            st_next.exp_smp = '0;
        end

        // Output stage
        if (CIC_DECIMATOR) begin
            st_next.out_vld = st_reg.cv[CIC_STAGES-1];
            if (st_reg.cv[CIC_STAGES-1]) begin
                st_next.out_smp = st_reg.cy[CIC_STAGES-1];
            end
        end else begin
            st_next.out_vld = integ_vld;
            if (integ_vld) begin
                st_next.out_smp = integ_out;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
            st_reg.rate <= CIC_RATE_INIT;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sample_out_o = st_reg.out_smp;
    assign out_valid_o = st_reg.out_vld;

endmodule
